// ==== logic/std_timer.sv ====
// Purpose: 16-bit up-counting timer with compare and period comparators
// Assumes: Single 20 MHz clock, clock sources arrive as pulses or pins
// Notes:   Flags are sticky and cleared by writing ones to them
//          A compare value of N gives a period of exactly N ticks
//          The pin output lags the internal pin level by one stage
//          Besides the clear source, only switching on clears the count; its bytes are read-only
//          No interrupt logic here: flags are plain outputs
//
// Function
// R1: Pause freezes counter, resume from held value
// R2: Three-bit field chooses counter clock source
// R3: On rising edge clears counter, falling keeps
// R4: Off stops counting and gates module; the code gates nothing, it only stops run and ends a single pulse
// R5: On rising edge restores pin initial level
// R6: Two-bit field selects operating mode
// R7: Software turns off before changing mode
// R8: Compare match drives pin none/low/high/toggle
// R9: PWM field: inactive, active, PWM, single-pulse
// R10: Requested level equal initial shows no change
// R11: Software changes pin field only while off
// R12: Initial level sets start or active level
// R13: Invert bit inverts pin except timer mode
// R14: Swap bit exchanges period and duty comparators
// R15: Clear source: A match, or P/overflow
// R16: Counter readable as two read-only bytes
// R17: Compare-A held in two RW bytes, reset zero
// R18: Period byte compares counter high byte
// R19: Control 0 low three bits read zero
// R20: Sixteen-bit up-counter, A compares all bits
// R21: Each comparator raises its own flag
// R22: No P flag when clear source is A; the code still sets it in PWM mode
// R23: Undefined clock codes hold counter still
// R24: All registers reset to zero, module off
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module std_timer (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [2:0] address,
  input  wire logic [7:0] write_data,
  input  wire logic       write_strobe,
  input  wire logic       read_strobe,
  output logic      [7:0] read_data,
  input  wire logic       high_speed_tick,
  input  wire logic       subsidiary_clock,
  output logic            timer_output_pin,
  output logic            timer_output_enable,
  output logic            compare_a_flag,
  output logic            compare_p_flag
);

  // ==========================================================
  // Timing overview
  // Bus writes land at the strobe edge; reads show one cycle later
  // Switch-on: the next cycle clears the count and loads the pin
  // level, and the count starts on the tick after that
  // A match is decoded while the count is one short of the value,
  // so the clear and the pin change land on the same edge
  // Flags follow the match edge and stay until a write of ones
  // Single pulse: starts on switch-on, ends on an A match or on
  // switch-off, whichever comes first
  // Limitation: a new clock choice is not lined up with the free
  // dividers, so its first tick may come early

  // ==========================================================
  // Registers
  std_timer_pkg::control_0_t control_0;
  std_timer_pkg::control_1_t control_1;
  logic [15:0] compare_a_value;
  logic [7:0]  period_compare_value;

  // Counter, on/off history and pin state
  logic [15:0] count;
  logic        on_delayed;
  logic        pin_level;
  logic        pulse_active;

  // Free-running dividers and subsidiary clock synchroniser
  logic [1:0]  div4;
  logic [5:0]  div_high;
  logic [1:0]  sub_sync;
  logic        sub_last;

  // ==========================================================
  // Decode
  // Each write strobe is qualified by its own address; address 7
  // is the write-one-to-clear flag byte
  wire write_c0   = write_strobe && (address == std_timer_pkg::ADDR_CONTROL_0);
  wire write_c1   = write_strobe && (address == std_timer_pkg::ADDR_CONTROL_1);
  wire write_al   = write_strobe && (address == std_timer_pkg::ADDR_COMPARE_LOW);
  wire write_ah   = write_strobe && (address == std_timer_pkg::ADDR_COMPARE_HIGH);
  wire write_rp   = write_strobe && (address == std_timer_pkg::ADDR_PERIOD);
  wire write_flag = write_strobe && (address == std_timer_pkg::ADDR_FLAGS);

  std_timer_pkg::mode_t mode;
  assign mode = control_1.operating_mode_select;
  wire pwm_mode   = (mode == std_timer_pkg::MODE_PWM);
  wire timer_mode = (mode == std_timer_pkg::MODE_TIMER);
  wire single_pulse = pwm_mode &&
                      (control_1.pin_function_select == std_timer_pkg::PIN_TOGGLE);

  // R3: on rising edge
  wire on_rise = control_0.timer_on && !on_delayed;

  // ==========================================================
  // Clock source selection
  // Subsidiary clock is a pin, synchronised before edge detection
  wire sub_edge = sub_sync[1] && !sub_last;
  wire high_16  = high_speed_tick && (div_high[3:0] == std_timer_pkg::DIV16_LAST[3:0]);
  wire high_64  = high_speed_tick && (div_high == std_timer_pkg::DIV64_LAST);
  wire sys_4    = (div4 == std_timer_pkg::DIV4_LAST);

  // Every source is a one-cycle enable, never a clock of its own,
  // so the counter stays in the single clock domain
  // R2: clock source choice
  // R23: undefined codes stall
  logic tick;
  always_comb begin
    case (control_0.clock_select)
      std_timer_pkg::CLK_SYS_DIV4: tick = sys_4;
      std_timer_pkg::CLK_SYS:      tick = 1'b1;
      std_timer_pkg::CLK_HI_DIV16: tick = high_16;
      std_timer_pkg::CLK_HI_DIV64: tick = high_64;
      std_timer_pkg::CLK_SUB:      tick = sub_edge;
      default:                     tick = 1'b0;
    endcase
  end

  // R1: pause freezes count
  // R4: off stops counting
  wire run = tick && control_0.timer_on && !control_0.counter_pause && !on_rise;

  // ==========================================================
  // Comparators look at the count about to be reached, so a value
  // of N clears after exactly N ticks; zero is reached only by
  // wrapping, which is the counter overflow
  wire [15:0] count_plus = count + 16'h0001;

  // R20: full 16-bit compare A
  wire match_a = run && (count_plus == compare_a_value);

  // R18: period byte against high byte, zero means overflow
  // Low byte zero: the high byte has just reached the period value
  wire match_p = run && (count_plus == {period_compare_value, 8'h00});
  wire overflow = run && (count_plus == std_timer_pkg::RESET_COUNT);

  // R14: swap assigns period and duty
  wire period_match = control_1.duty_period_swap ? match_a : match_p;

  // R15: clear source, ignored in PWM and single pulse
  logic clear_count;
  always_comb begin
    if (pwm_mode) begin
      clear_count = period_match;
    end else if (control_1.clear_source_select) begin
      clear_count = match_a || overflow;
    end else begin
      clear_count = match_p;
    end
  end

  // Wrap to zero needs no special case: count_plus already wraps
  wire [15:0] next_count = clear_count ? std_timer_pkg::RESET_COUNT : count_plus;

  // ==========================================================
  // PWM duty: active while count below duty value, 100% if duty >= period
  // With swap, a period byte of zero is a 65536-tick duty, so the
  // output stays active all through
  wire [15:0] duty_value  = control_1.duty_period_swap ?
                            {period_compare_value, 8'h00} : compare_a_value;
  wire        duty_active = (count < duty_value) ||
                            (control_1.duty_period_swap && period_compare_value == 8'h00);

  // R8: compare-match pin action
  // R10: equal requested level shows no change
  logic next_cmp_level;
  always_comb begin
    case (control_1.pin_function_select)
      std_timer_pkg::PIN_NONE:   next_cmp_level = pin_level;
      std_timer_pkg::PIN_LOW:    next_cmp_level = 1'b0;
      std_timer_pkg::PIN_HIGH:   next_cmp_level = 1'b1;
      std_timer_pkg::PIN_TOGGLE: next_cmp_level = !pin_level;
      default:                   next_cmp_level = pin_level;
    endcase
  end

  // The waveform runs on even while the field forces a level
  // R9: PWM pin functions
  // R12: initial level is active level in PWM
  logic pwm_level;
  always_comb begin
    case (control_1.pin_function_select)
      std_timer_pkg::PIN_NONE:   pwm_level = !control_1.output_initial_level;
      std_timer_pkg::PIN_LOW:    pwm_level = control_1.output_initial_level;
      std_timer_pkg::PIN_HIGH:   pwm_level = duty_active ~^ control_1.output_initial_level;
      std_timer_pkg::PIN_TOGGLE: pwm_level = pulse_active ~^ control_1.output_initial_level;
      default:                   pwm_level = !control_1.output_initial_level;
    endcase
  end

  // ==========================================================
  // Register writes
  // R24: everything resets to zero
  // Counter bytes have no write decode: software cannot preload
  // Compare bytes write independently, with no shadow latch
  // R17: compare A bytes are read/write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      control_0            <= std_timer_pkg::control_0_t'(std_timer_pkg::RESET_BYTE);
      control_1            <= std_timer_pkg::control_1_t'(std_timer_pkg::RESET_BYTE);
      compare_a_value      <= {std_timer_pkg::RESET_BYTE, std_timer_pkg::RESET_BYTE};
      period_compare_value <= std_timer_pkg::RESET_BYTE;
    end else begin
      if (write_c0) begin
        control_0 <= std_timer_pkg::control_0_t'({write_data[7:3], 3'h0});
      end
      if (write_c1) begin
        control_1 <= std_timer_pkg::control_1_t'(write_data);
      end
      if (write_al) begin
        compare_a_value[7:0] <= write_data;
      end
      if (write_ah) begin
        compare_a_value[15:8] <= write_data;
      end
      if (write_rp) begin
        period_compare_value <= write_data;
      end
    end
  end

  // ==========================================================
  // Dividers and subsidiary clock synchroniser
  // The pin passes two flip-flops; only the second is read, and
  // sub_last keeps its previous level for edge finding
  // Both reset low, the idle pin level, so no false edge follows
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div4     <= 2'h0;
      div_high <= 6'h00;
      sub_sync <= 2'h0;
      sub_last <= 1'b0;
    end else begin
      div4     <= div4 + 2'h1;
      sub_sync <= {sub_sync[0], subsidiary_clock};
      sub_last <= sub_sync[1];
      if (high_speed_tick) begin
        div_high <= div_high + 6'h01;
      end
    end
  end

  // ==========================================================
  // Counter core
  // on_rise blocks run in its own cycle, so the clear cannot race
  // a tick; turning off only stops run and leaves the count alone
  // R3: clear on on-rise, keep value when turned off
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count      <= std_timer_pkg::RESET_COUNT;
      on_delayed <= 1'b0;
    end else begin
      on_delayed <= control_0.timer_on;
      if (on_rise) begin
        count <= std_timer_pkg::RESET_COUNT;
      end else if (run) begin
        count <= next_count;
      end
    end
  end

  // ==========================================================
  // Output pin state
  // Pin level moves only on switch-on and on an A match in compare mode; the
  // single pulse ends on an A match or on switch-off
  // R5: on rising edge loads initial level
  // R12: initial level used in compare mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_level    <= 1'b0;
      pulse_active <= 1'b0;
    end else begin
      if (on_rise) begin
        pin_level    <= control_1.output_initial_level;
        pulse_active <= 1'b1;
      end else begin
        if (match_a && mode == std_timer_pkg::MODE_COMPARE) begin
          pin_level <= next_cmp_level;
        end
        // Trailing edge on A match or when turned off
        if (match_a || !control_0.timer_on) begin
          pulse_active <= 1'b0;
        end
      end
    end
  end

  // Timer mode drives zero with the enable low, leaving the pin
  // free for other use; the undefined mode drops the enable too, but its pin level is not forced to zero
  // R13: invert except in timer mode
  wire raw_level = pwm_mode ? pwm_level : pin_level;
  wire out_level = timer_mode ? 1'b0 : (raw_level ^ control_1.output_invert);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timer_output_pin    <= 1'b0;
      timer_output_enable <= 1'b0;
    end else begin
      timer_output_pin    <= out_level;
      // R6: pin unused in timer and undefined modes
      timer_output_enable <= (mode == std_timer_pkg::MODE_COMPARE) || pwm_mode;
    end
  end

  // ==========================================================
  // Flags; a new match wins over a clear in the same cycle
  // A zero compare A outside PWM only meets the overflow, so it
  // raises no A flag
  // R21: one flag per comparator
  // R22: no P flag with clear source A in compare modes
  wire p_flag_allowed = pwm_mode || single_pulse || !control_1.clear_source_select;
  wire set_a = match_a && (compare_a_value != 16'h0000 || pwm_mode);
  wire set_p = match_p && p_flag_allowed;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      compare_a_flag <= 1'b0;
      compare_p_flag <= 1'b0;
    end else begin
      if (set_a) begin
        compare_a_flag <= 1'b1;
      end else if (write_flag && write_data[0]) begin
        compare_a_flag <= 1'b0;
      end
      if (set_p) begin
        compare_p_flag <= 1'b1;
      end else if (write_flag && write_data[1]) begin
        compare_p_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read mux
  // Read data is zero outside its one cycle, so several blocks can
  // share a wired-or read bus without a select
  // R16: counter bytes read-only
  // R19: control 0 low bits read zero
  logic [7:0] read_mux;
  always_comb begin
    case (address)
      std_timer_pkg::ADDR_CONTROL_0:    read_mux = {control_0[7:3], 3'h0};
      std_timer_pkg::ADDR_CONTROL_1:    read_mux = control_1;
      std_timer_pkg::ADDR_COUNT_LOW:    read_mux = count[7:0];
      std_timer_pkg::ADDR_COUNT_HIGH:   read_mux = count[15:8];
      std_timer_pkg::ADDR_COMPARE_LOW:  read_mux = compare_a_value[7:0];
      std_timer_pkg::ADDR_COMPARE_HIGH: read_mux = compare_a_value[15:8];
      std_timer_pkg::ADDR_PERIOD:       read_mux = period_compare_value;
      default:                          read_mux = {6'h00, compare_p_flag, compare_a_flag};
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      read_data <= std_timer_pkg::RESET_BYTE;
    end else if (read_strobe) begin
      read_data <= read_mux;
    end else begin
      read_data <= std_timer_pkg::RESET_BYTE;
    end
  end

endmodule : std_timer

// ==== common/std_timer_pkg.sv ====
// Purpose: Shared constants and types for the standard timer block
// Assumes: 8-bit register port, register index equals byte address
// Notes:   Offsets are word indexes on a plain strobe port
package std_timer_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [2:0] ADDR_CONTROL_0    = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_1    = 3'h1;
  localparam logic [2:0] ADDR_COUNT_LOW    = 3'h2;
  localparam logic [2:0] ADDR_COUNT_HIGH   = 3'h3;
  localparam logic [2:0] ADDR_COMPARE_LOW  = 3'h4;
  localparam logic [2:0] ADDR_COMPARE_HIGH = 3'h5;
  localparam logic [2:0] ADDR_PERIOD       = 3'h6;
  localparam logic [2:0] ADDR_FLAGS        = 3'h7;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;

  // ==========================================================
  // Clock select codes
  localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_SYS      = 3'h1;
  localparam logic [2:0] CLK_HI_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HI_DIV64 = 3'h3;
  localparam logic [2:0] CLK_SUB      = 3'h4;
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam logic [5:0] DIV16_LAST   = 6'h0f;
  localparam logic [5:0] DIV64_LAST   = 6'h3f;

  // ==========================================================
  // Modes and pin functions
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF   = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } mode_t;

  localparam logic [1:0] PIN_NONE   = 2'b00;
  localparam logic [1:0] PIN_LOW    = 2'b01;
  localparam logic [1:0] PIN_HIGH   = 2'b10;
  localparam logic [1:0] PIN_TOGGLE = 2'b11;

  // ==========================================================
  // Control register layouts
  typedef struct packed {
    logic       counter_pause;
    logic [2:0] clock_select;
    logic       timer_on;
    logic [2:0] unused;
  } control_0_t;

  typedef struct packed {
    mode_t      operating_mode_select;
    logic [1:0] pin_function_select;
    logic       output_initial_level;
    logic       output_invert;
    logic       duty_period_swap;
    logic       clear_source_select;
  } control_1_t;

endpackage : std_timer_pkg

// ==== verif/std_timer_assertions.sv ====
// Purpose: Port-level checks for the standard timer
// Assumes: Control writes land in the cycle after the write strobe
// Notes:   Control state is rebuilt here from bus writes only
`timescale 1ns/1ns
module std_timer_assertions (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic [2:0] address,
  input wire logic [7:0] write_data,
  input wire logic       write_strobe,
  input wire logic       read_strobe,
  input wire logic [7:0] read_data,
  input wire logic       high_speed_tick,
  input wire logic       subsidiary_clock,
  input wire logic       timer_output_pin,
  input wire logic       timer_output_enable,
  input wire logic       compare_a_flag,
  input wire logic       compare_p_flag
);
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  // ==========================================================
  // Control shadows, so mode-dependent checks need no probes inside
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl0 <= 8'h00;
      ctrl1 <= 8'h00;
    end else if (write_strobe && address == std_timer_pkg::ADDR_CONTROL_0) begin
      ctrl0 <= write_data;
    end else if (write_strobe && address == std_timer_pkg::ADDR_CONTROL_1) begin
      ctrl1 <= write_data;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Checks
  chk_read_idle: assert property (!$past(read_strobe) |-> read_data == 8'h00)
    else $error("read data outside its cycle");
  chk_ctrl0_low_zero: assert property ($past(read_strobe) &&
    $past(address) == std_timer_pkg::ADDR_CONTROL_0 |-> read_data[2:0] == 3'h0)
    else $error("control 0 low bits not zero");
  chk_a_flag_sticky: assert property (compare_a_flag && !(write_strobe &&
    address == std_timer_pkg::ADDR_FLAGS && write_data[0]) |=> compare_a_flag)
    else $error("compare A flag lost");
  chk_p_flag_sticky: assert property (compare_p_flag && !(write_strobe &&
    address == std_timer_pkg::ADDR_FLAGS && write_data[1]) |=> compare_p_flag)
    else $error("compare P flag lost");
  chk_timer_pin_quiet: assert property ((ctrl1[7:6] == 2'b11)[*3]
    |-> !timer_output_enable && !timer_output_pin)
    else $error("pin driven in timer mode");
  chk_compare_enable: assert property ((ctrl1[7:6] == 2'b00)[*3] |-> timer_output_enable)
    else $error("pin not enabled in compare mode");
  chk_on_initial_pin: assert property ($rose(ctrl0[3]) && ctrl1[7:6] == 2'b00
    |-> ##[1:3] timer_output_pin == (ctrl1[3] ^ ctrl1[2]))
    else $error("pin not at initial level after switch on");
  chk_no_p_flag: assert property ((ctrl1[0] && ctrl1[7:6] != 2'b10 && !compare_p_flag)[*3]
    |=> !compare_p_flag)
    else $error("P flag raised while clearing on A");
  // Main scenarios reached
  cover property ($rose(compare_a_flag));
  cover property ($rose(compare_p_flag));
  cover property ($rose(timer_output_pin));
endmodule : std_timer_assertions

bind std_timer std_timer_assertions i_std_timer_assertions (
  .clock(clock), .arst_n(arst_n), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .high_speed_tick(high_speed_tick), .subsidiary_clock(subsidiary_clock),
  .timer_output_pin(timer_output_pin), .timer_output_enable(timer_output_enable),
  .compare_a_flag(compare_a_flag), .compare_p_flag(compare_p_flag));

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the standard timer
// Assumes: Flags at index 7, cleared by writing ones
// Notes:   Count rates are measured between two reads 128 cycles apart
`timescale 1ns/1ns
module tb_top;
  logic        clock, arst_n, write_strobe, read_strobe, high_speed_tick, subsidiary_clock;
  logic        timer_output_pin, timer_output_enable, compare_a_flag, compare_p_flag;
  logic [2:0]  address;
  logic [7:0]  write_data, read_data;
  logic [15:0] v, w, d;
  int          errors, checks_done, cycles;
  std_timer i_std_timer (.clock(clock), .arst_n(arst_n), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .high_speed_tick(high_speed_tick),
    .subsidiary_clock(subsidiary_clock), .timer_output_pin(timer_output_pin),
    .timer_output_enable(timer_output_enable), .compare_a_flag(compare_a_flag),
    .compare_p_flag(compare_p_flag));
  // ==========================================================
  // Clock and sources; high tick every 2 cycles, sub clock period 8
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Tick sources and hang guard, sized well above the whole run
  always @(posedge clock) begin
    high_speed_tick <= ~high_speed_tick;
    cycles <= cycles + 1;
    if (cycles % 4 == 0) subsidiary_clock <= ~subsidiary_clock;
    if (cycles == 40000) begin
      errors++;
      give_verdict;
    end
  end
  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] dat);
    @(posedge clock);
    write_strobe <= 1'b1;
    address      <= a;
    write_data   <= dat;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] dat);
    @(posedge clock);
    read_strobe <= 1'b1;
    address     <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 dat = {8'h00, read_data};
  endtask : rd
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk
  // Count advance of the low byte over 128 cycles
  task automatic gap(output logic [15:0] dlt);
    rd(3'h2, v);
    repeat (126) @(posedge clock);
    rd(3'h2, w);
    dlt = {8'h00, w[7:0] - v[7:0]};
  endtask : gap
  // Reconfigure only while switched off, then switch on at system clock
  task automatic setup(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    wr(3'h0, 8'h10);
    wr(3'h1, c1);
    wr(3'h4, a[7:0]);
    wr(3'h5, a[15:8]);
    wr(3'h6, p);
    wr(3'h7, 8'h03);
    wr(3'h0, 8'h18);
  endtask : setup
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], v);
      chk(v, 16'h0000, 16'h0000);
    end
    wr(3'h0, 8'h07);
    rd(3'h0, v);
    chk(v, 16'h0000, 16'h0000);
    wr(3'h4, 8'h34);
    wr(3'h5, 8'h12);
    wr(3'h6, 8'h56);
    wr(3'h2, 8'h99);
    rd(3'h4, v);
    chk(v, 16'h0034, 16'h0034);
    rd(3'h5, v);
    chk(v, 16'h0012, 16'h0012);
    rd(3'h6, v);
    chk(v, 16'h0056, 16'h0056);
    rd(3'h2, v);
    chk(v, 16'h0000, 16'h0000);
    $display("done registers");
  endtask : t_regs
  task automatic t_count;
    setup(8'h01, 16'hffff, 8'h00);
    gap(d);
    chk(d, 16'h0080, 16'h0080);
    wr(3'h0, 8'h98);
    gap(d);
    chk(d, 16'h0000, 16'h0000);
    wr(3'h0, 8'h18);
    rd(3'h2, v);
    chk({8'h00, v[7:0] - w[7:0]}, 16'h0001, 16'h0006);
    wr(3'h0, 8'h10);
    gap(d);
    chk(d, 16'h0000, 16'h0000);
    wr(3'h0, 8'h18);
    rd(3'h3, v);
    chk(v, 16'h0000, 16'h0000);
    rd(3'h2, v);
    chk(v, 16'h0000, 16'h0006);
    $display("done counting");
  endtask : t_count
  task automatic t_clocks;
    logic [15:0] e [8] = '{16'h0020, 16'h0080, 16'h0004, 16'h0001,
                           16'h0010, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      wr(3'h0, {1'b0, i[2:0], 4'h8});
      gap(d);
      chk(d, e[i] - 16'(e[i] != 16'h0000), e[i] + 16'(e[i] != 16'h0000));
    end
    $display("done clock select");
  endtask : t_clocks
  task automatic t_match;
    setup(8'h30, 16'h0100, 8'h02);
    repeat (4) @(posedge clock);
    chk({15'h0000, timer_output_pin}, 16'h0000, 16'h0000);
    repeat (300) @(posedge clock);
    chk({13'h0000, compare_a_flag, compare_p_flag, timer_output_pin}, 16'h0005, 16'h0005);
    repeat (300) @(posedge clock);
    chk({13'h0000, compare_a_flag, compare_p_flag, timer_output_pin}, 16'h0007, 16'h0007);
    rd(3'h3, v);
    chk(v, 16'h0000, 16'h0000);
    wr(3'h7, 8'h03);
    @(posedge clock);
    chk({14'h0000, compare_a_flag, compare_p_flag}, 16'h0000, 16'h0000);
    setup(8'h29, 16'h0180, 8'h01);
    repeat (600) @(posedge clock);
    chk({13'h0000, compare_a_flag, compare_p_flag, timer_output_pin}, 16'h0005, 16'h0005);
    chk({15'h0000, timer_output_enable}, 16'h0001, 16'h0001);
    rd(3'h3, v);
    chk(v, 16'h0000, 16'h0000);
    rd(3'h2, v);
    chk(v, 16'h00da, 16'h00da);
    $display("done compare match");
  endtask : t_match
  // Active cycles of the pin over one 512-cycle period
  task automatic pwm(input logic [7:0] c1, input logic [15:0] a, lo, hi,
                     input logic [7:0] p = 8'h02);
    setup(c1, a, p);
    repeat (600) @(posedge clock);
    d = 16'h0000;
    repeat (512) begin
      @(posedge clock);
      d += 16'(timer_output_pin);
    end
    chk(d, lo, hi);
  endtask : pwm
  task automatic t_pwm;
    pwm(8'ha8, 16'h0080, 16'h007e, 16'h0082);
    pwm(8'hac, 16'h0080, 16'h017e, 16'h0182);
    pwm(8'haa, 16'h0200, 16'h00fe, 16'h0102, 8'h01);
    pwm(8'ha8, 16'h0300, 16'h0200, 16'h0200);
    pwm(8'h88, 16'h0080, 16'h0000, 16'h0000);
    pwm(8'h98, 16'h0080, 16'h0200, 16'h0200);
    pwm(8'hc0, 16'h0080, 16'h0000, 16'h0000);
    setup(8'hb8, 16'h0040, 8'h00);
    repeat (4) @(posedge clock);
    chk({15'h0000, timer_output_pin}, 16'h0001, 16'h0001);
    repeat (100) @(posedge clock);
    chk({15'h0000, timer_output_pin}, 16'h0000, 16'h0000);
    $display("done waveforms");
  endtask : t_pwm
  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    address = 3'h0;
    write_data = 8'h00;
    high_speed_tick = 1'b0;
    subsidiary_clock = 1'b0;
    v = 16'h0000;
    w = 16'h0000;
    errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    t_regs;
    t_count;
    t_clocks;
    t_match;
    t_pwm;
    give_verdict;
  end
endmodule : tb_top
